/* hdl/nvmac_pkg.sv */
// Purpose: shared constants and types for the data nonvolatile access controller
// Assumes: 250 MHz core clock, Avalon-MM register slave, 32-bit data
// Notes:   byte registers sit in bits 7:0 of aligned words

package nvmac_pkg;

    // ************************************************************
    // geometry and timing
    // ************************************************************
    localparam int NVM_DEPTH     = 256;
    localparam int IDX_W         = 8;
    localparam int BYTE_W        = 8;
    localparam int TMR_W         = 20;
    localparam int CLK_PERIOD_NS = 4;
    localparam int ERASE_TIME_NS = 2000000;
    localparam int PROG_TIME_NS  = 2000000;
    localparam int ERASE_CYC     = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CYC      = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_UNLOCK = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_BUF    = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_IDX    = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_FLAGS2 = 5'h10;

    // ************************************************************
    // values
    // ************************************************************
    localparam logic [BYTE_W-1:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [BYTE_W-1:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;
    localparam logic [BYTE_W-1:0] RST_BYTE    = 8'h00;
    localparam int                DONE_BIT    = 4;

    typedef struct packed {
        logic       code_space_select;
        logic       config_space_select;
        logic [1:0] rsv;
        logic       interrupted_program_flag;
        logic       modify_permit;
        logic       wr_start;
        logic       rd_start;
    } nvmac_ctrl_s;

    localparam nvmac_ctrl_s CTRL_RST = 8'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} nvmac_state_e;
    typedef enum logic [1:0] {UNL_LOCKED, UNL_HALF, UNL_OPEN} nvmac_unlock_e;

endpackage

/* hdl/nvmac_top.sv */
// Purpose: byte-wide data nonvolatile array behind indirect control registers
// Assumes: bus master on CLOCK; RST_B covers every reset source
// Notes:   array contents are not touched by reset
//
// What this block does
// [R1] 256 bytes, 8-bit index, byte buffer
// [R2] array reached only through these registers
// [R3] write erases location, then programs it
// [R4] internal timer sets write duration
// [R5] unlock port reads zero, no storage
// [R6] code select picks program memory or data
// [R7] config select overrides code select; SPACE_SEL carries both bits, code select refuses reads even under config
// [R8] write start ignored while permit is clear
// [R9] clearing permit never aborts write
// [R10] software keeps permit clear when idle
// [R11] reset during write sets error flag
// [R12] reset clears index and buffer
// [R13] start bits set by software, hardware clears
// [R14] read start refused in code space
// [R15] write end sets done flag, software clears
// [R16] unlock key pair precedes write start
// [R17] read lands in buffer next cycle
// [R18] start stays set through timed interval

`timescale 1ns/1ns

module nvmac_top
    import nvmac_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_CYC,
    parameter int PROG_CYCLES  = PROG_CYC
) (
    input  wire logic              CLOCK,
    input  wire logic              RST_B,
    input  wire logic [ADDR_W-1:0] ADDRESS,
    input  wire logic              READ,
    input  wire logic              WRITE,
    input  wire logic [31:0]       WRITEDATA,
    input  wire logic [3:0]        BYTEENABLE,
    output logic [31:0]            READDATA,
    output logic                   WAITREQUEST,
    output logic                   NVM_DONE_FLAG,
    output logic [1:0]             SPACE_SEL
);

    // ************************************************************
    // storage and state
    // ************************************************************
    logic [BYTE_W-1:0] mem_q [NVM_DEPTH];
    nvmac_ctrl_s       ctrl_q;
    nvmac_ctrl_s       wbyte;
    nvmac_state_e      st_q;
    nvmac_unlock_e     unl_q;
    logic [IDX_W-1:0]  idx_q;
    logic [BYTE_W-1:0] buf_q;
    logic [IDX_W-1:0]  wr_idx_q;
    logic [BYTE_W-1:0] wr_dat_q;
    logic              wr_data_sp_q;
    logic [TMR_W-1:0]  tmr_q;
    logic              done_q;
    logic              wait_q;
    logic [31:0]       rdata_q;
    logic [1:0]        space_q;
    logic [BYTE_W-1:0] rd_mux;
    logic              req;
    logic              acc_wr;
    logic              wr_ctrl;
    logic              wr_unl;
    logic              wr_buf;
    logic              wr_idx;
    logic              wr_flg;
    logic              start_wr;
    logic              start_rd;
    logic              rd_data_sp;
    logic              fin_wr;

    // ************************************************************
    // bus slave
    // ************************************************************
    assign req    = READ | WRITE;
    assign acc_wr = WRITE & ~wait_q & BYTEENABLE[0];
    assign wbyte  = WRITEDATA[7:0];

    assign wr_ctrl = acc_wr && (ADDRESS == OFF_CTRL);
    assign wr_unl  = acc_wr && (ADDRESS == OFF_UNLOCK);
    assign wr_buf  = acc_wr && (ADDRESS == OFF_BUF);
    assign wr_idx  = acc_wr && (ADDRESS == OFF_IDX);
    assign wr_flg  = acc_wr && (ADDRESS == OFF_FLAGS2);

    // one wait cycle, then answer
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            wait_q <= 1'b1;
        end else if (req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // array only visible through these registers
    always_comb begin
        rd_mux = RST_BYTE;
        case (ADDRESS)
            OFF_CTRL:   rd_mux = ctrl_q; // [R2]
            OFF_UNLOCK: rd_mux = RST_BYTE; // [R5]
            OFF_BUF:    rd_mux = buf_q;
            OFF_IDX:    rd_mux = idx_q;
            OFF_FLAGS2: rd_mux[DONE_BIT] = done_q;
            default:    rd_mux = RST_BYTE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            rdata_q <= 32'h0;
        end else if (READ && wait_q) begin
            rdata_q <= {24'h0, rd_mux};
        end
    end

    // ************************************************************
    // unlock sequence
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            unl_q <= UNL_LOCKED;
        end else if (wr_unl) begin
            if (wbyte == UNLOCK_KEY1) begin
                unl_q <= UNL_HALF; // [R16]
            end else if (wbyte == UNLOCK_KEY2 && unl_q == UNL_HALF) begin
                unl_q <= UNL_OPEN; // [R16]
            end else begin
                unl_q <= UNL_LOCKED;
            end
        end else if (wr_ctrl) begin
            unl_q <= UNL_LOCKED;
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    assign start_wr = wr_ctrl && wbyte.wr_start && ctrl_q.modify_permit // [R8]
                      && unl_q == UNL_OPEN && st_q == ST_IDLE; // [R16]
    assign start_rd = wr_ctrl && wbyte.rd_start && !wbyte.code_space_select // [R14]
                      && st_q == ST_IDLE && !ctrl_q.rd_start;
    assign rd_data_sp = !ctrl_q.code_space_select && !ctrl_q.config_space_select;
    assign fin_wr   = st_q == ST_PROG && tmr_q == '0;

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            ctrl_q <= CTRL_RST;
            ctrl_q.interrupted_program_flag <= (st_q != ST_IDLE)
                                               | ctrl_q.interrupted_program_flag; // [R11]
        end else begin
            if (wr_ctrl) begin
                ctrl_q.code_space_select   <= wbyte.code_space_select; // [R6]
                ctrl_q.config_space_select <= wbyte.config_space_select; // [R7]
                ctrl_q.modify_permit       <= wbyte.modify_permit; // [R9]
                ctrl_q.interrupted_program_flag <= ctrl_q.interrupted_program_flag
                                                   & wbyte.interrupted_program_flag;
            end
            if (start_wr) begin
                ctrl_q.wr_start <= 1'b1; // [R13]
            end else if (fin_wr) begin
                ctrl_q.wr_start <= 1'b0; // [R13]
            end
            if (start_rd) begin
                ctrl_q.rd_start <= 1'b1; // [R13]
            end else if (ctrl_q.rd_start) begin
                ctrl_q.rd_start <= 1'b0; // [R17]
            end
        end
    end

    // target space seen by the rest of the chip
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            space_q <= 2'h0;
        end else begin
            space_q <= {ctrl_q.config_space_select, ctrl_q.code_space_select}; // [R7]
        end
    end

    // ************************************************************
    // index and byte buffer
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            idx_q <= '0; // [R12]
        end else if (wr_idx) begin
            idx_q <= wbyte; // [R1]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            buf_q <= RST_BYTE; // [R12]
        end else if (ctrl_q.rd_start && rd_data_sp) begin
            buf_q <= mem_q[idx_q]; // [R17]
        end else if (wr_buf) begin
            buf_q <= wbyte;
        end
    end

    // ************************************************************
    // self-timed erase and program
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            st_q  <= ST_IDLE;
            tmr_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (start_wr) begin
                        st_q  <= ST_ERASE; // [R3]
                        tmr_q <= TMR_W'(ERASE_CYCLES - 1); // [R4]
                    end
                end
                ST_ERASE: begin
                    if (tmr_q == '0) begin
                        st_q  <= ST_PROG;
                        tmr_q <= TMR_W'(PROG_CYCLES - 1); // [R4]
                    end else begin
                        tmr_q <= tmr_q - 1'b1; // [R18]
                    end
                end
                ST_PROG: begin
                    if (tmr_q == '0) begin
                        st_q <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 1'b1; // [R18]
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // operands frozen at launch
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            wr_idx_q     <= '0;
            wr_dat_q     <= RST_BYTE;
            wr_data_sp_q <= 1'b0;
        end else if (start_wr) begin
            wr_idx_q     <= idx_q;
            wr_dat_q     <= buf_q;
            wr_data_sp_q <= !wbyte.code_space_select && !wbyte.config_space_select; // [R6]
        end
    end

    // array: no reset, contents persist
    always_ff @(posedge CLOCK) begin
        if (start_wr && !wbyte.code_space_select && !wbyte.config_space_select) begin
            mem_q[idx_q] <= ERASED_BYTE; // [R3]
        end else if (fin_wr && wr_data_sp_q) begin
            mem_q[wr_idx_q] <= wr_dat_q; // [R3]
        end
    end

    // done flag: set wins over software clear
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            done_q <= 1'b0;
        end else if (fin_wr) begin
            done_q <= 1'b1; // [R15]
        end else if (wr_flg && !WRITEDATA[DONE_BIT]) begin
            done_q <= 1'b0; // [R15]
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign READDATA      = rdata_q;
    assign WAITREQUEST   = wait_q;
    assign NVM_DONE_FLAG = done_q;
    assign SPACE_SEL     = space_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLOCK);
    endclocking

    default disable iff (!RST_B);

    chk_wr_needs_permit: assert property ( // [R8]
        $rose(ctrl_q.wr_start) |-> $past(ctrl_q.modify_permit))
        else $error("write started without permit");

    chk_wr_needs_key: assert property ( // [R16]
        $rose(ctrl_q.wr_start) |-> $past(unl_q) == UNL_OPEN)
        else $error("write started without unlock keys");

    chk_rd_code_space: assert property ( // [R14]
        $rose(ctrl_q.rd_start) |-> !ctrl_q.code_space_select)
        else $error("read started in code space");

    chk_rd_one_cycle: assert property ( // [R17]
        ctrl_q.rd_start && rd_data_sp && !wr_idx
        |=> !ctrl_q.rd_start && buf_q == mem_q[idx_q])
        else $error("read result not in buffer");

    chk_start_holds: assert property ( // [R18]
        st_q != ST_IDLE |-> ctrl_q.wr_start)
        else $error("start bit dropped during write");

    chk_timer_load: assert property ( // [R4]
        st_q == ST_IDLE && start_wr |=> st_q == ST_ERASE && tmr_q == TMR_W'(ERASE_CYCLES - 1))
        else $error("erase timer not loaded");

    chk_erase_first: assert property ( // [R3]
        $rose(st_q == ST_PROG) && wr_data_sp_q |-> mem_q[wr_idx_q] == ERASED_BYTE)
        else $error("location not erased before program");

    chk_permit_no_abort: assert property ( // [R9]
        st_q == ST_ERASE && !ctrl_q.modify_permit |=> st_q == ST_ERASE || st_q == ST_PROG)
        else $error("write aborted by permit clear");

    chk_done_flag: assert property ( // [R15]
        fin_wr |=> done_q && !ctrl_q.wr_start ##1 done_q || $past(wr_flg))
        else $error("done flag not raised at write end");

    chk_unlock_reads_zero: assert property ( // [R5]
        READ && !wait_q && ADDRESS == OFF_UNLOCK |-> READDATA == 32'h0)
        else $error("unlock port read nonzero");

    chk_reset_mid_write: assert property (@(posedge CLOCK) disable iff (1'b0) // [R11]
        !RST_B && st_q != ST_IDLE |=> ctrl_q.interrupted_program_flag && idx_q == '0 && buf_q == '0)
        else $error("interrupted write not flagged");

    chk_write_lands: assert property ( // [R3]
        fin_wr && wr_data_sp_q |=> mem_q[wr_idx_q] == wr_dat_q)
        else $error("programmed byte not stored");

    chk_space_follows: assert property ( // [R7]
        1'b1 |=> space_q == {$past(ctrl_q.config_space_select), $past(ctrl_q.code_space_select)})
        else $error("space select output stale");

endmodule // nvmac_top

/* sim/nvmac_top_test.sv */
// Purpose: self-checking bench for the nonvolatile access controller
// Assumes: short erase and program counts, bus master on CLOCK
// Notes:   each scenario is a task that drives the bus and judges the result

`timescale 1ns/1ns

module nvmac_top_test;
    import nvmac_pkg::*;

    localparam int ERASE_N = 4;
    localparam int PROG_N  = 5;

    logic              CLOCK;
    logic              RST_B;
    logic [ADDR_W-1:0] ADDRESS;
    logic              READ;
    logic              WRITE;
    logic [31:0]       WRITEDATA;
    logic [3:0]        BYTEENABLE;
    logic [31:0]       READDATA;
    logic              WAITREQUEST;
    logic              NVM_DONE_FLAG;
    logic [1:0]        SPACE_SEL;
    int                fails;
    int                checks_done;
    int                cycles = 0;
    logic [31:0]       rd;

    nvmac_top #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) i_nvmac_top (
        .CLOCK(CLOCK), .RST_B(RST_B), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .NVM_DONE_FLAG(NVM_DONE_FLAG), .SPACE_SEL(SPACE_SEL));

    // ************************************************************
    // clock, timeout, verdict
    // ************************************************************
    initial begin
        CLOCK = 1'b0;
        forever #2 CLOCK = ~CLOCK;
    end

    task automatic wrap_up();
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // ************************************************************
    // bus and sequence helpers
    // ************************************************************
    task automatic bus(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] wd,
                       output logic [31:0] d);
        @(posedge CLOCK);
        ADDRESS   <= a;
        WRITE     <= w;
        READ      <= ~w;
        WRITEDATA <= {24'h000000, wd};
        do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
        d = READDATA;
        WRITE <= 1'b0;
        READ  <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge CLOCK);
        RST_B <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
    endtask

    task automatic write_seq(input logic [7:0] idx, input logic [7:0] dat, input logic perm,
                             input logic keys);
        bus(OFF_IDX, 1'b1, idx, rd);
        bus(OFF_BUF, 1'b1, dat, rd);
        bus(OFF_CTRL, 1'b1, {5'h00, perm, 2'b00}, rd);
        if (keys) begin
            bus(OFF_UNLOCK, 1'b1, UNLOCK_KEY1, rd);
            bus(OFF_UNLOCK, 1'b1, UNLOCK_KEY2, rd);
        end
        bus(OFF_CTRL, 1'b1, 8'h06, rd);
    endtask

    task automatic read_loc(input logic [7:0] idx, input logic [7:0] exp);
        bus(OFF_IDX, 1'b1, idx, rd);
        bus(OFF_BUF, 1'b1, 8'h00, rd);
        bus(OFF_CTRL, 1'b1, 8'h01, rd);
        bus(OFF_CTRL, 1'b0, 8'h00, rd);
        check(rd, 32'h0);
        bus(OFF_BUF, 1'b0, 8'h00, rd);
        check(rd, {24'h000000, exp});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_state();
        logic [ADDR_W-1:0] offs [6];
        offs = '{OFF_IDX, OFF_BUF, OFF_UNLOCK, 5'h14, OFF_CTRL, OFF_FLAGS2};
        check({29'h0, WAITREQUEST, SPACE_SEL}, 32'h4);
        bus(OFF_CTRL, 1'b1, 8'h00, rd);
        bus(OFF_UNLOCK, 1'b1, UNLOCK_KEY1, rd);
        bus(5'h14, 1'b1, 8'hff, rd);
        // low byte lane off: index write must be ignored
        BYTEENABLE <= 4'h0;
        bus(OFF_IDX, 1'b1, 8'hff, rd);
        BYTEENABLE <= 4'h1;
        foreach (offs[i]) begin
            bus(offs[i], 1'b0, 8'h00, rd);
            check(rd, 32'h0);
        end
    endtask

    task automatic t_write_read(input logic [7:0] idx, input logic [7:0] dat, input logic drop);
        int n;
        n = 0;
        write_seq(idx, dat, 1'b1, 1'b1);
        if (drop) begin
            bus(OFF_CTRL, 1'b1, 8'h00, rd);
        end
        do begin
            bus(OFF_CTRL, 1'b0, 8'h00, rd);
            if (rd[1] === 1'b1) begin
                n++;
                check({31'h0, NVM_DONE_FLAG}, 32'h0);
            end
        end while (rd[1] !== 1'b0);
        check({31'h0, n > 0}, 32'h1);
        check({31'h0, NVM_DONE_FLAG}, 32'h1);
        bus(OFF_FLAGS2, 1'b0, 8'h00, rd);
        check(rd, 32'h1 << DONE_BIT);
        bus(OFF_FLAGS2, 1'b1, 8'h00, rd);
        @(posedge CLOCK);
        check({31'h0, NVM_DONE_FLAG}, 32'h0);
        read_loc(idx, dat);
    endtask

    task automatic t_refused(input logic perm, input logic keys);
        write_seq(8'h00, 8'h11, perm, keys);
        bus(OFF_CTRL, 1'b0, 8'h00, rd);
        check({31'h0, rd[1]}, 32'h0);
        repeat (ERASE_N + PROG_N + 2) @(posedge CLOCK);
        check({31'h0, NVM_DONE_FLAG}, 32'h0);
        read_loc(8'h00, 8'ha5);
    endtask

    task automatic t_space();
        logic [7:0] sel [4];
        sel = '{8'h40, 8'hc0, 8'h80, 8'h00};
        bus(OFF_BUF, 1'b1, 8'h3c, rd);
        bus(OFF_CTRL, 1'b1, 8'h81, rd);
        bus(OFF_CTRL, 1'b0, 8'h00, rd);
        check(rd, 32'h80);
        bus(OFF_BUF, 1'b0, 8'h00, rd);
        check(rd, 32'h3c);
        foreach (sel[i]) begin
            bus(OFF_CTRL, 1'b1, sel[i], rd);
            repeat (2) @(posedge CLOCK);
            check({30'h0, SPACE_SEL}, {30'h0, sel[i][6], sel[i][7]});
        end
    endtask

    task automatic t_reset_mid();
        write_seq(8'h10, 8'h77, 1'b1, 1'b1);
        do_reset();
        check({31'h0, NVM_DONE_FLAG}, 32'h0);
        bus(OFF_CTRL, 1'b0, 8'h00, rd);
        check(rd & 32'h0b, 32'h08);
        bus(OFF_IDX, 1'b0, 8'h00, rd);
        check(rd, 32'h0);
        bus(OFF_BUF, 1'b0, 8'h00, rd);
        check(rd, 32'h0);
        bus(OFF_CTRL, 1'b1, 8'h00, rd);
        bus(OFF_CTRL, 1'b0, 8'h00, rd);
        check(rd, 32'h0);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        fails       = 0;
        checks_done = 0;
        RST_B       = 1'b0;
        ADDRESS     = '0;
        READ        = 1'b0;
        WRITE       = 1'b0;
        WRITEDATA   = 32'h0;
        BYTEENABLE  = 4'h1;
        do_reset();
        t_reset_state();
        t_write_read(8'h00, 8'h5a, 1'b0);
        t_write_read(8'hff, 8'hc3, 1'b0);
        t_write_read(8'h00, 8'ha5, 1'b1);
        t_refused(1'b0, 1'b1);
        t_refused(1'b1, 1'b0);
        t_space();
        t_reset_mid();
        wrap_up();
    end

endmodule // nvmac_top_test
